// File: core/pmt_pkg.sv
// Constants, register map and helpers for the eight-bit period match timer
package pmt_pkg;

    // Register bus widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [2:0] OFS_COUNTER = 3'h0;
    localparam logic [2:0] OFS_LIMIT   = 3'h1;
    localparam logic [2:0] OFS_CONTROL = 3'h2;
    localparam logic [2:0] OFS_FLAGS   = 3'h3;
    localparam logic [2:0] OFS_CLEAR   = 3'h4;
    localparam logic [2:0] OFS_ENABLE  = 3'h5;

    // Control field positions
    localparam int CTL_PRE_LSB  = 0;
    localparam int CTL_PRE_MSB  = 1;
    localparam int CTL_RUN_BIT  = 2;
    localparam int CTL_POST_LSB = 3;
    localparam int CTL_POST_MSB = 6;
    localparam int CTL_IMPL_W   = 7;

    // Position of the period event flag in the request, clear and enable registers
    localparam int FLAG_BIT = 1;

    // Reset values
    localparam logic [7:0] COUNTER_RST = 8'h00;
    localparam logic [7:0] LIMIT_RST   = 8'hff;
    localparam logic [6:0] CONTROL_RST = 7'h00;

    // Instruction clock is the oscillator divided by this figure
    localparam int         INSTR_DIV  = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

    // Last prescaler count for a given select code
    function automatic logic [3:0] pre_last(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'hf;
        if (sel == 2'h0)
        begin
            r = 4'h0;
        end
        else if (sel == 2'h1)
        begin
            r = 4'h3;
        end
        return r;
    endfunction

endpackage

// File: core/pmt_postscale.sv
// Output postscaler of the period match timer: one event per ratio+1 matches
`timescale 1ns/1ps
`default_nettype none
module pmt_postscale (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_clear,
    input  wire logic       i_match,
    input  wire logic [3:0] i_ratio,
    output logic            o_event
);

    typedef struct packed {
        logic [3:0] cnt;
    } pmt_post_state_t;

    pmt_post_state_t s_q;
    pmt_post_state_t s_d;
    logic            at_last;

    // Ratio is field plus one, so the field itself is the last count
    assign at_last = (s_q.cnt >= i_ratio);
    assign o_event = i_match && at_last && !i_clear;

    // Next count
    always_comb
    begin
        s_d = s_q;
        if (i_clear)
        begin
            s_d.cnt = 4'h0;
        end
        else if (i_match)
        begin
            s_d.cnt = at_last ? 4'h0 : s_q.cnt + 4'h1;
        end
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// File: core/pmt_prescale.sv
// Input prescaler of the period match timer: divides instruction ticks by 1, 4 or 16
`timescale 1ns/1ps
`default_nettype none
module pmt_prescale (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_clear,
    input  wire logic       i_tick,
    input  wire logic [1:0] i_select,
    output logic            o_pulse
);

    typedef struct packed {
        logic [3:0] cnt;
    } pmt_pre_state_t;

    pmt_pre_state_t s_q;
    pmt_pre_state_t s_d;
    logic           at_last;

    // Terminal count for the selected ratio
    assign at_last = (s_q.cnt >= pmt_pkg::pre_last(i_select));
    // A clear swallows any pulse of the same cycle
    assign o_pulse = i_tick && at_last && !i_clear;

    // Next count
    always_comb
    begin
        s_d = s_q;
        if (i_clear)
        begin
            s_d.cnt = 4'h0;
        end
        else if (i_tick)
        begin
            s_d.cnt = at_last ? 4'h0 : s_q.cnt + 4'h1;
        end
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// File: core/pmt_timer.sv
// Top of the eight-bit period match timer with its register port and interrupt
`timescale 1ns/1ps
`default_nettype none
module pmt_timer (
    input  wire logic                       I_MCLK,
    input  wire logic                       I_SYS_RST,
    input  wire logic [pmt_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [pmt_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic                       I_WR,
    input  wire logic                       I_RD,
    output logic      [pmt_pkg::DATA_W-1:0] O_RDATA,
    output logic                            O_IRQ,
    output logic                            O_MATCH
);

    // Whole state of the timer top
    typedef struct packed {
        logic [1:0] quarter;
        logic [7:0] counter;
        logic [7:0] limit;
        logic [6:0] control;
        logic       flag;
        logic       flag_en;
        logic [7:0] rdata;
    } pmt_state_t;

    pmt_state_t s_q;
    pmt_state_t s_d;

    // Decoded accesses
    logic wr_counter;
    logic wr_limit;
    logic wr_control;
    logic wr_clear;
    logic wr_enable;

    // Control fields
    logic [1:0] input_divide_select;
    logic [3:0] output_divide_select;
    logic       run_bit;

    // Timing chain
    logic instr_tick;
    logic count_tick;
    logic stage_clear;
    logic is_match;
    logic wrap;
    logic post_event;

    // Read mux
    logic [7:0] read_value;

    // Register write decode
    always_comb
    begin
        wr_counter = I_WR && (I_ADDR == pmt_pkg::OFS_COUNTER);
        wr_limit   = I_WR && (I_ADDR == pmt_pkg::OFS_LIMIT);
        wr_control = I_WR && (I_ADDR == pmt_pkg::OFS_CONTROL);
        wr_clear   = I_WR && (I_ADDR == pmt_pkg::OFS_CLEAR);
        wr_enable  = I_WR && (I_ADDR == pmt_pkg::OFS_ENABLE);
    end

    // Fields of the control register
    assign input_divide_select  = s_q.control[pmt_pkg::CTL_PRE_MSB:pmt_pkg::CTL_PRE_LSB];
    assign output_divide_select = s_q.control[pmt_pkg::CTL_POST_MSB:pmt_pkg::CTL_POST_LSB];
    assign run_bit              = s_q.control[pmt_pkg::CTL_RUN_BIT];

    // Instruction clock tick, one oscillator cycle in four
    assign instr_tick = (s_q.quarter == pmt_pkg::INSTR_LAST);

    // Writes to counter or control restart both divider stages
    assign stage_clear = wr_counter || wr_control;

    // Continuous equality between counter and limit
    assign is_match = (s_q.counter == s_q.limit);
    assign O_MATCH  = is_match;

    // Increment on a match returns to zero and feeds the postscaler
    assign wrap = count_tick && is_match && !wr_counter;

    // Prescaler sits between the instruction tick and the counter
    pmt_prescale u_prescale (
        .i_clk    (I_MCLK),
        .i_rst    (I_SYS_RST),
        .i_clear  (stage_clear),
        .i_tick   (instr_tick && run_bit),
        .i_select (input_divide_select),
        .o_pulse  (count_tick)
    );

    // Postscaler counts wraps of the counter
    pmt_postscale u_postscale (
        .i_clk    (I_MCLK),
        .i_rst    (I_SYS_RST),
        .i_clear  (stage_clear),
        .i_match  (wrap),
        .i_ratio  (output_divide_select),
        .o_event  (post_event)
    );

    // Read multiplexer; write-only and unmapped offsets read zero
    always_comb
    begin
        read_value = 8'h00;
        unique case (I_ADDR)
            pmt_pkg::OFS_COUNTER:
            begin
                read_value = s_q.counter;
            end
            pmt_pkg::OFS_LIMIT:
            begin
                read_value = s_q.limit;
            end
            pmt_pkg::OFS_CONTROL:
            begin
                read_value = {1'b0, s_q.control};
            end
            pmt_pkg::OFS_FLAGS:
            begin
                read_value[pmt_pkg::FLAG_BIT] = s_q.flag;
            end
            pmt_pkg::OFS_ENABLE:
            begin
                read_value[pmt_pkg::FLAG_BIT] = s_q.flag_en;
            end
            default:
            begin
                read_value = 8'h00;
            end
        endcase
    end

    // Next state of the whole block
    always_comb
    begin
        s_d = s_q;

        // Free running quarter divider for the instruction clock
        s_d.quarter = s_q.quarter + 2'h1;

        // Counter: software write wins over an increment
        if (wr_counter)
        begin
            s_d.counter = I_WDATA;
        end
        else if (wrap)
        begin
            s_d.counter = 8'h00;
        end
        else if (count_tick)
        begin
            s_d.counter = s_q.counter + 8'h01;
        end

        // Period limit
        if (wr_limit)
        begin
            s_d.limit = I_WDATA;
        end

        // Control; the counter is left alone here
        if (wr_control)
        begin
            s_d.control = I_WDATA[pmt_pkg::CTL_IMPL_W-1:0];
        end

        // Interrupt enable
        if (wr_enable)
        begin
            s_d.flag_en = I_WDATA[pmt_pkg::FLAG_BIT];
        end

        // Sticky flag; a new event wins over a clear in the same cycle
        if (wr_clear && I_WDATA[pmt_pkg::FLAG_BIT])
        begin
            s_d.flag = 1'b0;
        end
        if (post_event)
        begin
            s_d.flag = 1'b1;
        end

        // Read data stand only in the cycle after the strobe
        s_d.rdata = I_RD ? read_value : 8'h00;
    end

    // State register with synchronous reset
    always_ff @(posedge I_MCLK)
    begin
        if (I_SYS_RST)
        begin
            s_q.quarter <= 2'h0;
            s_q.counter <= pmt_pkg::COUNTER_RST;
            s_q.limit   <= pmt_pkg::LIMIT_RST;
            s_q.control <= pmt_pkg::CONTROL_RST;
            s_q.flag    <= 1'b0;
            s_q.flag_en <= 1'b0;
            s_q.rdata   <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign O_RDATA = s_q.rdata;
    assign O_IRQ   = s_q.flag && s_q.flag_en;

endmodule
`default_nettype wire

// File: verif/pmt_timer_props.sv
// Port level properties of the period match timer
`timescale 1ns/1ps
`default_nettype none
module pmt_chk (
    input wire logic       I_MCLK,
    input wire logic       I_SYS_RST,
    input wire logic [2:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic       I_WR,
    input wire logic       I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic       O_IRQ,
    input wire logic       O_MATCH
);
    // One clock domain, checks paused in reset
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_SYS_RST);
    // Limit written, then read on the next cycle
    sequence lim_wr_rd;
        I_WR && I_ADDR == 3'h1 ##1 I_RD && I_ADDR == 3'h1;
    endsequence
    // Match change by a tick, then no writes in that cycle or the two after it
    sequence match_quiet;
        $changed(O_MATCH) && !$past(I_WR) ##0 !I_WR [*3];
    endsequence
    chk_rd_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data outside read cycle");
    chk_lim_back: assert property (lim_wr_rd |=> O_RDATA == $past(I_WDATA, 2))
        else $error("limit read back wrong");
    chk_lim_reset:
    assert property ($fell(I_SYS_RST) && I_RD && I_ADDR == 3'h1 |=> O_RDATA == 8'hff)
        else $error("limit not all ones after reset");
    chk_ctl_top: assert property (I_RD && I_ADDR == 3'h2 |=> !O_RDATA[7])
        else $error("control bit 7 not zero");
    chk_irq_flag: assert property (I_RD && I_ADDR == 3'h3 && O_IRQ |=> O_RDATA[1])
        else $error("interrupt without flag");
    chk_irq_hold:
    assert property (O_IRQ && !(I_WR && I_ADDR inside {3'h4, 3'h5}) |=> O_IRQ)
        else $error("interrupt dropped without clear");
    chk_irq_mask: assert property (I_WR && I_ADDR == 3'h5 && !I_WDATA[1] |=> !O_IRQ)
        else $error("interrupt while disabled");
    chk_tick_gap: assert property (match_quiet |=> $stable(O_MATCH))
        else $error("counter moved faster than ticks");
endmodule

bind pmt_timer pmt_chk chk_u (
    .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_MATCH(O_MATCH)
);
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench of the period match timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        I_MCLK      = 1'b0;
    logic        I_SYS_RST   = 1'b1;
    logic [2:0]  I_ADDR      = 3'h0;
    logic [7:0]  I_WDATA     = 8'h00;
    logic        I_WR        = 1'b0;
    logic        I_RD        = 1'b0;
    logic [7:0]  O_RDATA;
    logic        O_IRQ;
    logic        O_MATCH;
    logic [31:0] rnd         = 32'h1f8004ea;
    int          error_cnt   = 0;
    int          check_count = 0;

    // 40 MHz system clock
    always #12.5 I_MCLK = ~I_MCLK;

    pmt_timer dut_u (
        .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_MATCH(O_MATCH)
    );

    // Stimulus shift register and expected interrupt delay
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int exp_clk(input logic [1:0] s, input logic [3:0] p,
                                   input logic [7:0] l);
        int d;
        d = (s == 2'h0) ? 1 : ((s == 2'h1) ? 4 : 16);
        return 4 * (int'(l) + 1) * (int'(p) + 1) * d;
    endfunction

    // Compare tasks and verdict
    task chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_rng(input int n, input int lo, input int hi);
        check_count++;
        if (n < lo || n > hi)
        begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h..%h", $time, n, lo, hi);
        end
    endtask
    task results;
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Register bus cycles, entered just after a rising edge
    task wr(input logic [2:0] a, input logic [7:0] d);
        I_WR <= 1'b1;
        I_RD <= 1'b0;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_MCLK);
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        I_RD <= 1'b1;
        I_WR <= 1'b0;
        I_ADDR <= a;
        @(posedge I_MCLK);
        I_RD <= 1'b0;
        @(negedge I_MCLK);
        chk(O_RDATA, e);
        @(posedge I_MCLK);
    endtask
    task idle(input int n);
        I_WR <= 1'b0;
        repeat (n) @(posedge I_MCLK);
    endtask

    // One timed period run, then flag, mask, clear and stop checks
    task run(input logic [1:0] s, input logic [3:0] p, input logic [7:0] l);
        int t;
        int n;
        t = exp_clk(s, p, l);
        n = 0;
        wr(3'h1, l);
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h02);
        wr(3'h5, 8'h02);
        wr(3'h2, {1'b0, p, 1'b1, s});
        idle(0);
        while (O_IRQ !== 1'b1 && n < t + 16)
        begin
            @(negedge I_MCLK);
            n++;
        end
        chk_rng(n, t - 6, t + 6);
        idle(20);
        chk({7'h00, O_IRQ}, 8'h01);
        rd(3'h3, 8'h02);
        wr(3'h5, 8'h00);
        rd(3'h3, 8'h02);
        chk({7'h00, O_IRQ}, 8'h00);
        wr(3'h4, 8'h02);
        rd(3'h1, l);
        wr(3'h0, rnd[15:8]);
        wr(3'h2, {1'b1, p, 1'b0, s});
        rd(3'h3, 8'h00);
        idle(40);
        rd(3'h0, rnd[15:8]);
        rd(3'h2, {1'b0, p, 1'b0, s});
        // Stopped counter against a limit written to the same value
        wr(3'h1, rnd[15:8]);
        idle(1);
        @(negedge I_MCLK);
        chk({7'h00, O_MATCH}, 8'h01);
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge I_MCLK);
        I_SYS_RST <= 1'b0;
        rd(3'h1, 8'hff);
        rd(3'h0, 8'h00);
        rd(3'h2, 8'h00);
        for (int a = 4; a < 8; a++)
            rd(3'(a), 8'h00);
        @(negedge I_MCLK);
        chk({7'h00, O_MATCH}, 8'h00);
        @(posedge I_MCLK);
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            wr(3'h1, rnd[23:16]);
            rd(3'h1, rnd[23:16]);
            run(i[1:0], (i == 4) ? 4'hf : rnd[5:2],
                (i == 5) ? 8'hff : ((i == 4) ? 8'h00 : {6'h00, rnd[1:0]}));
        end
        results();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (80000) @(posedge I_MCLK);
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire
